/* File: ucw_pkg.sv */
// Constants and types of the wake, card retry and driver-enable control.
// Assumes one 200 MHz clock shared by APB and the serial core.
// Contract
// - Third control register sits at 0x08 and resets to all zeros.
// - Wake interrupt enable bit 22 gates the deep-sleep wake interrupt.
// - Wake select 00 address match, 10 start bit, 11 buffer full; 01 reserved.
// - Wake select, polarity and mode writes ignored while unit enabled.
// - In card mode, bits 19:17 give retry count for transmit and receive.
// - Card transmit raises frame error only after retries are used up.
// - Card receive raises buffer full and parity error after count reached.
// - Retry count zero means no automatic retransmission.
// - While enabled only zero may be written to retry count; stops retries.
// - Driver enable active high when bit 15 is 0, low when 1.
// - Bit 14 routes driver enable onto the RTS pin.
// - Second unit treats wake enable, wake select and retry count as reserved.
// - Address wake compares 4 bits when match mode 0, full width when 1.
package ucw_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] UCW_OFF_CTL = 8'h00;
	localparam logic [7:0] UCW_OFF_CTL3 = 8'h08;
	localparam logic [7:0] UCW_OFF_STS = 8'h1c;
	localparam logic [7:0] UCW_OFF_MSK = 8'h20;
	localparam logic [31:0] UCW_RST_CTL = 32'h0000_0000;
	localparam logic [31:0] UCW_RST_CTL3 = 32'h0000_0000;
	localparam logic [3:0] UCW_RST_STS = 4'h0;
	localparam logic [3:0] UCW_RST_MSK = 4'h0;
	localparam int UCW_B_ON = 0;
	localparam int UCW_B_CARD = 1;
	localparam int UCW_B_ADDRESS_MATCH_MODE = 4;
	localparam int UCW_B_NODE = 24;
	localparam int UCW_B_WIE = 22;
	localparam int UCW_B_WSEL = 20;
	localparam int UCW_B_RTY = 17;
	localparam int UCW_B_DEP = 15;
	localparam int UCW_B_DEM = 14;
	localparam logic [31:0] UCW_CTL3_KEEP = 32'h007e_ffff;
	localparam logic [31:0] UCW_CTL_KEEP = 32'hff00_0013;
	localparam int UCW_S_WAKE = 0;
	localparam int UCW_S_FRAME_ERROR_FLAG = 1;
	localparam int UCW_S_PARITY_ERROR_FLAG = 2;
	localparam int UCW_S_RBF = 3;
	localparam logic [1:0] UCW_WAKE_ADDR = 2'h0;
	localparam logic [1:0] UCW_WAKE_START = 2'h2;
	localparam logic [1:0] UCW_WAKE_RBF = 2'h3;
	// ****************************************
	// Timing
	// ****************************************
	localparam int UCW_CLK_NS = 5;
	localparam int UCW_DE_LEAD_NS = 10;
	localparam int UCW_DE_LEAD_CYC = (UCW_DE_LEAD_NS + UCW_CLK_NS - 1)
		/ UCW_CLK_NS;
	typedef enum logic [1:0] {
		UCW_DE_IDLE = 2'b00,
		UCW_DE_LEAD = 2'b01,
		UCW_DE_SEND = 2'b11
	} ucw_de_state_type;
	typedef struct packed {
		logic start_bit;
		logic addr_valid;
		logic [7:0] addr_byte;
		logic rx_done;
		logic rx_parity_bad;
		logic tx_done;
		logic tx_nack;
	} ucw_core_ev_type;
endpackage

/* File: ucw_retry.sv */
// Smartcard retry counter for one direction.
// Assumes attempt results arrive as single-cycle pulses on clk.
`timescale 1ns/10ps
module ucw_retry import ucw_pkg::*; #(
	parameter int CNT_W = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Attempt results
	input wire logic [CNT_W-1:0] limit,
	input wire logic attempt_ok,
	input wire logic attempt_bad,
	// Decision
	output logic retry,
	output logic give_up
);
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	wire logic spare = cnt_reg < limit;
	// Limit zero gives up on the first failure
	assign retry = attempt_bad && spare;
	assign give_up = attempt_bad && !spare;
	assign cnt_next = (attempt_ok || give_up) ? '0 :
		retry ? cnt_reg + 1'b1 : cnt_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end
	property p_zero_no_retry;
		@(posedge clk) disable iff (!nrst)
		(attempt_bad && limit == '0) |-> (!retry && give_up);
	endproperty
	a_zero_no_retry: assert property (p_zero_no_retry)
		else $error("retry taken with zero limit");
	property p_give_up_at_limit;
		@(posedge clk) disable iff (!nrst)
		give_up |-> (cnt_reg >= limit) ##1 (cnt_reg == '0);
	endproperty
	a_give_up_at_limit: assert property (p_give_up_at_limit)
		else $error("gave up before retries were used");
endmodule

/* File: ucw_de.sv */
// Driver-enable sequencer: leads the first bit and trails the last stop bit.
// Assumes the core holds tx_req until tx_go and tx_busy to the last stop bit.
`timescale 1ns/10ps
module ucw_de import ucw_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Core side
	input wire logic enable,
	input wire logic tx_req,
	input wire logic tx_busy,
	// Results
	output logic tx_go,
	output logic de_on
);
	ucw_de_state_type st_reg;
	ucw_de_state_type st_next;
	logic [1:0] lead_reg;
	// Count is zero in the first lead cycle, so the last one is CYC-1
	wire logic lead_done = lead_reg == 2'(UCW_DE_LEAD_CYC - 1);
	// Without the mode the core starts at once; no lead time is spent
	assign tx_go = enable ? (st_reg == UCW_DE_SEND && tx_req) : tx_req;
	assign de_on = st_reg != UCW_DE_IDLE;
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			UCW_DE_IDLE: if (enable && tx_req) st_next = UCW_DE_LEAD;
			UCW_DE_LEAD: if (lead_done) st_next = UCW_DE_SEND;
			UCW_DE_SEND: if (!tx_req && !tx_busy) st_next = UCW_DE_IDLE;
			default: st_next = UCW_DE_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= UCW_DE_IDLE;
			lead_reg <= 2'h0;
		end else begin
			st_reg <= st_next;
			lead_reg <= (st_reg == UCW_DE_LEAD) ? lead_reg + 2'h1 : 2'h0;
		end
	end
	sequence s_lead;
		(st_reg == UCW_DE_LEAD) [*2];
	endsequence
	property p_lead_first;
		@(posedge clk) disable iff (!nrst)
		(enable && $rose(tx_go)) |-> $past(st_reg == UCW_DE_LEAD);
	endproperty
	a_lead_first: assert property (p_lead_first)
		else $error("first bit started without driver enable lead");
	property p_lead_ends;
		@(posedge clk) disable iff (!nrst)
		s_lead |=> (st_reg == UCW_DE_SEND);
	endproperty
	a_lead_ends: assert property (p_lead_ends)
		else $error("driver enable lead too long");
endmodule

/* File: ucw_ctrl.sv */
// Top of the wake, card retry and driver-enable control of a serial unit.
// Assumes an APB master on clk and core event pulses on the same clock.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module ucw_ctrl import ucw_pkg::*; #(
	parameter bit SECOND_UNIT = 1'b0,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial core events
	input wire ucw_core_ev_type ev,
	input wire logic deep_sleep,
	input wire logic tx_req,
	input wire logic tx_busy,
	input wire logic rts_flow,
	// Serial core commands
	output logic tx_go,
	output logic tx_retry,
	output logic rx_nack,
	// Pins and interrupts
	output logic driver_enable_out,
	output logic rts_pin,
	output logic wake_irq,
	output logic irq
);
	// ****************************************
	// Bus decode
	// ****************************************
	logic [31:0] ctl_reg;
	logic [31:0] ctl3_reg;
	logic [3:0] sts_reg;
	logic [3:0] msk_reg;
	logic [31:0] rdata_reg;
	logic err_reg;
	logic [31:0] ctl3_next;
	logic [3:0] sts_next;
	logic [31:0] rd_mux;
	logic de_level_reg;
	logic rts_reg;
	logic rbf_set;
	wire logic hit_ctl = paddr == UCW_OFF_CTL;
	wire logic hit_ctl3 = paddr == UCW_OFF_CTL3;
	wire logic hit_sts = paddr == UCW_OFF_STS;
	wire logic hit_msk = paddr == UCW_OFF_MSK;
	wire logic mapped = hit_ctl | hit_ctl3 | hit_sts | hit_msk;
	wire logic setup = psel && !penable;
	wire logic access = psel && penable;
	wire logic wr = access && pwrite && mapped;
	wire logic rd_sts = access && !pwrite && hit_sts;
	assign pready = 1'b1;
	assign prdata = rdata_reg;
	assign pslverr = err_reg && access;
	assign rd_mux = hit_ctl ? ctl_reg :
		hit_ctl3 ? ctl3_reg :
		hit_sts ? {28'h0, sts_reg} :
		hit_msk ? {28'h0, msk_reg} : 32'h0;

	// ****************************************
	// Control fields
	// ****************************************
	wire logic unit_on = ctl_reg[UCW_B_ON];
	wire logic card_mode = ctl_reg[UCW_B_CARD];
	wire logic address_match_mode = ctl_reg[UCW_B_ADDRESS_MATCH_MODE];
	wire logic [ADDR_W-1:0] node_addr = ctl_reg[UCW_B_NODE +: ADDR_W];
	wire logic wake_irq_en = ctl3_reg[UCW_B_WIE];
	wire logic [1:0] wake_event_sel = ctl3_reg[UCW_B_WSEL +: 2];
	wire logic [2:0] card_retry_count = ctl3_reg[UCW_B_RTY +: 3];
	wire logic drv_en_polarity = ctl3_reg[UCW_B_DEP];
	wire logic drv_en_mode = ctl3_reg[UCW_B_DEM];
	wire logic [2:0] new_retry = pwdata[UCW_B_RTY +: 3];

	// ****************************************
	// Write masking of the third control register
	// ****************************************
	// Bits under lock keep their value while the unit runs
	wire logic wr3 = wr && hit_ctl3;
	wire logic wie_ok = wr3 && !SECOND_UNIT;
	wire logic wsel_ok = wr3 && !SECOND_UNIT && !unit_on;
	// A running unit only takes zero, which stops retransmission
	wire logic rty_ok = wr3 && !SECOND_UNIT
		&& (!unit_on || new_retry == 3'h0);
	wire logic de_ok = wr3 && !unit_on;
	always_comb begin
		ctl3_next = ctl3_reg;
		if (wr3)
			ctl3_next[13:0] = pwdata[13:0];
		if (wie_ok)
			ctl3_next[UCW_B_WIE] = pwdata[UCW_B_WIE];
		if (wsel_ok)
			ctl3_next[UCW_B_WSEL +: 2] = pwdata[UCW_B_WSEL +: 2];
		if (rty_ok)
			ctl3_next[UCW_B_RTY +: 3] = new_retry;
		if (de_ok) begin
			ctl3_next[UCW_B_DEP] = pwdata[UCW_B_DEP];
			ctl3_next[UCW_B_DEM] = pwdata[UCW_B_DEM];
		end
		// Reserved bits stay zero whatever software writes
		ctl3_next = ctl3_next & UCW_CTL3_KEEP;
	end

	// ****************************************
	// Register file
	// ****************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctl_reg <= UCW_RST_CTL;
			ctl3_reg <= UCW_RST_CTL3;
			msk_reg <= UCW_RST_MSK;
			rdata_reg <= 32'h0;
			err_reg <= 1'b0;
		end else begin
			if (wr && hit_ctl)
				ctl_reg <= pwdata & UCW_CTL_KEEP;
			ctl3_reg <= ctl3_next;
			if (wr && hit_msk)
				msk_reg <= pwdata[3:0];
			if (setup)
				rdata_reg <= pwrite ? 32'h0 : rd_mux;
			if (setup)
				err_reg <= !mapped;
		end
	end

	// ****************************************
	// Wake event
	// ****************************************
	// Four-bit compare looks at the low nibble only
	wire logic addr_hit = address_match_mode ?
		(ev.addr_byte[ADDR_W-1:0] == node_addr) :
		(ev.addr_byte[3:0] == node_addr[3:0]);
	wire logic ev_addr = ev.addr_valid && addr_hit;
	// Code 01 selects nothing, so no wake comes from it
	wire logic wake_ev = deep_sleep && !SECOND_UNIT && (
		(wake_event_sel == UCW_WAKE_ADDR && ev_addr) ||
		(wake_event_sel == UCW_WAKE_START && ev.start_bit) ||
		(wake_event_sel == UCW_WAKE_RBF && rbf_set));

	// ****************************************
	// Smartcard retries
	// ****************************************
	logic tx_give_up;
	logic rx_give_up;
	logic rx_retry;
	wire logic card = card_mode && !SECOND_UNIT;
	wire logic [2:0] eff_retry = card ? card_retry_count : 3'h0;
	ucw_retry #(
		.CNT_W(3)
	) u_tx_retry (
		.clk(clk),
		.nrst(nrst),
		.limit(eff_retry),
		.attempt_ok(ev.tx_done),
		.attempt_bad(card && ev.tx_nack),
		.retry(tx_retry),
		.give_up(tx_give_up)
	);
	ucw_retry #(
		.CNT_W(3)
	) u_rx_retry (
		.clk(clk),
		.nrst(nrst),
		.limit(eff_retry),
		.attempt_ok(ev.rx_done && !ev.rx_parity_bad),
		.attempt_bad(card && ev.rx_done && ev.rx_parity_bad),
		.retry(rx_retry),
		.give_up(rx_give_up)
	);
	assign rx_nack = rx_retry;
	// Outside card mode every frame lands; in it only good or final ones
	assign rbf_set = card ? (rx_give_up ||
		(ev.rx_done && !ev.rx_parity_bad)) : ev.rx_done;
	wire logic parity_error_flag_set = card ? rx_give_up :
		(ev.rx_done && ev.rx_parity_bad);
	wire logic frame_error_flag_set = tx_give_up;

	// ****************************************
	// Sticky status, cleared by reading it
	// ****************************************
	wire logic [3:0] sts_set = {rbf_set, parity_error_flag_set, frame_error_flag_set, wake_ev};
	// A set in the clearing cycle survives the read
	assign sts_next = (rd_sts ? 4'h0 : sts_reg) | sts_set;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			sts_reg <= UCW_RST_STS;
		else
			sts_reg <= sts_next;
	end
	wire logic wake_flag = sts_reg[UCW_S_WAKE];
	wire logic [3:0] irq_gate = {3'h7, wake_irq_en};
	assign wake_irq = wake_flag && wake_irq_en;
	assign irq = |(sts_reg & msk_reg & irq_gate);

	// ****************************************
	// Driver enable
	// ****************************************
	logic de_on;
	ucw_de u_de (
		.clk(clk),
		.nrst(nrst),
		.enable(drv_en_mode),
		.tx_req(tx_req),
		.tx_busy(tx_busy),
		.tx_go(tx_go),
		.de_on(de_on)
	);
	// Idle level follows polarity even with the mode off
	wire logic de_level = (drv_en_mode && de_on) ^ drv_en_polarity;
	wire logic rts_next = drv_en_mode ? de_level : rts_flow;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			de_level_reg <= 1'b0;
			rts_reg <= 1'b0;
		end else begin
			de_level_reg <= de_level;
			rts_reg <= rts_next;
		end
	end
	assign driver_enable_out = de_level_reg;
	assign rts_pin = rts_reg;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_wr3_locked;
		wr3 && unit_on;
	endsequence
	property p_lock_fields;
		@(posedge clk) disable iff (!nrst)
		s_wr3_locked |=> ($stable(wake_event_sel) && $stable(drv_en_polarity)
			&& $stable(drv_en_mode));
	endproperty
	a_lock_fields: assert property (p_lock_fields)
		else $error("locked field changed while unit enabled");
	property p_retry_zero_only;
		@(posedge clk) disable iff (!nrst)
		(s_wr3_locked and (new_retry != 3'h0)) |=> $stable(card_retry_count);
	endproperty
	a_retry_zero_only: assert property (p_retry_zero_only)
		else $error("nonzero retry count taken while enabled");
	property p_retry_clear;
		@(posedge clk) disable iff (!nrst)
		(s_wr3_locked and (new_retry == 3'h0 && !SECOND_UNIT))
			|=> (card_retry_count == 3'h0);
	endproperty
	a_retry_clear: assert property (p_retry_clear)
		else $error("retry count not cleared while enabled");
	property p_de_polarity;
		@(posedge clk) disable iff (!nrst)
		##1 driver_enable_out ==
			($past(drv_en_mode && de_on) ^ $past(drv_en_polarity));
	endproperty
	a_de_polarity: assert property (p_de_polarity)
		else $error("driver enable level wrong for polarity");
	property p_rts_route;
		@(posedge clk) disable iff (!nrst)
		drv_en_mode |=> (rts_pin == driver_enable_out);
	endproperty
	a_rts_route: assert property (p_rts_route)
		else $error("driver enable not on RTS pin");
	property p_start_wake;
		@(posedge clk) disable iff (!nrst)
		(deep_sleep && ev.start_bit && !SECOND_UNIT
			&& wake_event_sel == UCW_WAKE_START) |=> wake_flag;
	endproperty
	a_start_wake: assert property (p_start_wake)
		else $error("start bit did not raise wake flag");
	property p_wake_irq;
		@(posedge clk) disable iff (!nrst)
		(wake_flag && !wake_irq_en) |-> !wake_irq;
	endproperty
	a_wake_irq: assert property (p_wake_irq)
		else $error("wake interrupt while disabled");
	property p_card_rx_fail;
		@(posedge clk) disable iff (!nrst)
		rx_give_up |=> (sts_reg[UCW_S_RBF] && sts_reg[UCW_S_PARITY_ERROR_FLAG]);
	endproperty
	a_card_rx_fail: assert property (p_card_rx_fail)
		else $error("receive failure flags not raised");
	property p_tx_frame_error_flag;
		@(posedge clk) disable iff (!nrst)
		(card && ev.tx_nack && !tx_give_up) |=> !$rose(sts_reg[UCW_S_FRAME_ERROR_FLAG]);
	endproperty
	a_tx_frame_error_flag: assert property (p_tx_frame_error_flag)
		else $error("frame error before retries used up");
	property p_reserved_zero;
		@(posedge clk) disable iff (!nrst)
		ctl3_reg[31:23] == 9'h0 && ctl3_reg[16] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits not zero");
	property p_ctl3_read;
		@(posedge clk) disable iff (!nrst)
		(setup && !pwrite && hit_ctl3) |=> (prdata == $past(ctl3_reg));
	endproperty
	a_ctl3_read: assert property (p_ctl3_read)
		else $error("third control register read wrong");
	property p_wake_irq_on;
		@(posedge clk) disable iff (!nrst)
		(wake_flag && wake_irq_en && msk_reg[UCW_S_WAKE]) |-> (wake_irq && irq);
	endproperty
	a_wake_irq_on: assert property (p_wake_irq_on)
		else $error("enabled wake did not interrupt");
	property p_addr4_wake;
		@(posedge clk) disable iff (!nrst)
		(deep_sleep && !SECOND_UNIT && wake_event_sel == UCW_WAKE_ADDR
			&& ev.addr_valid && !address_match_mode
			&& ev.addr_byte[3:0] == node_addr[3:0]) |=> wake_flag;
	endproperty
	a_addr4_wake: assert property (p_addr4_wake)
		else $error("four-bit address match did not wake");
	property p_addr_full_miss;
		@(posedge clk) disable iff (!nrst)
		(wake_event_sel == UCW_WAKE_ADDR && ev.addr_valid
			&& address_match_mode
			&& ev.addr_byte[ADDR_W-1:0] != node_addr) |-> !wake_ev;
	endproperty
	a_addr_full_miss: assert property (p_addr_full_miss)
		else $error("full address mismatch raised wake");
	property p_zero_limit_tx;
		@(posedge clk) disable iff (!nrst)
		(card && ev.tx_nack && card_retry_count == 3'h0)
			|-> (!tx_retry && tx_give_up);
	endproperty
	a_zero_limit_tx: assert property (p_zero_limit_tx)
		else $error("retransmission with zero retry count");
	property p_rts_flow;
		@(posedge clk) disable iff (!nrst)
		!drv_en_mode |=> (rts_pin == $past(rts_flow));
	endproperty
	a_rts_flow: assert property (p_rts_flow)
		else $error("RTS pin lost flow control with mode off");
	property p_second_fields;
		@(posedge clk) disable iff (!nrst)
		SECOND_UNIT |-> (ctl3_reg[UCW_B_RTY +: 6] == 6'h0 && !wake_irq);
	endproperty
	a_second_fields: assert property (p_second_fields)
		else $error("second unit holds wake or retry setting");
endmodule

/* File: ucw_xcvr_model.sv */
// Behavioural line transceiver together with the core's transmit handshake.
// Assumes clk, reset, and the driver-enable and RTS pins of ucw_ctrl.
`timescale 1ns/10ps
module ucw_xcvr_model #(
	parameter int FRAME = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Stimulus and pins
	input wire logic send,
	input wire logic pol,
	input wire logic de,
	input wire logic rts,
	input wire logic tx_go,
	// Handshake and results
	output logic tx_req,
	output logic tx_busy,
	output logic [7:0] bad,
	output logic [7:0] frames
);
	// ****************************************
	// Frame sender
	// ****************************************
	int n;
	// A bit sent while the line driver is off is lost, so each counts bad
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_req <= 1'b0;
			tx_busy <= 1'b0;
			bad <= 8'h00;
			frames <= 8'h00;
			n <= 0;
		end else if (tx_req && tx_go) begin
			tx_req <= 1'b0;
			tx_busy <= 1'b1;
			n <= FRAME;
			if (de !== ~pol)
				bad <= bad + 8'h01;
		end else if (tx_busy) begin
			if (de !== ~pol || rts !== de)
				bad <= bad + 8'h01;
			if (n == 1) begin
				tx_busy <= 1'b0;
				frames <= frames + 8'h01;
			end
			n <= n - 1;
		end else if (send) begin
			tx_req <= 1'b1;
		end
	end
endmodule

/* File: uart_wake_retry_driver_ctrl_tb.sv */
// Self-checking bench of ucw_ctrl over APB with a transceiver model.
// Assumes the designer's note: pready answers, events are one-cycle pulses.
`timescale 1ns/10ps
module uart_wake_retry_driver_ctrl_tb import ucw_pkg::*; ();
	// ****************************************
	// Signals and instances
	// ****************************************
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	ucw_core_ev_type ev = '0;
	logic deep_sleep = 1'b0;
	logic rts_flow = 1'b0;
	logic send = 1'b0;
	logic pol = 1'b0;
	logic [31:0] prdata, prdata2, cap, cap2;
	logic pready, pslverr, cap_err, tx_req, tx_busy, tx_go, tx_retry, rx_nack;
	logic driver_enable_out, rts_pin, wake_irq, irq, got_retry, got_nack;
	logic [7:0] bad, frames;
	int err_count = 0;
	int num_checks = 0;
	logic [31:0] w_ctl [4] = '{32'h5a00_0000, 32'h5a00_0010, 32'h5a00_0000,
		32'h5a00_0000};
	logic [31:0] w_c3 [4] = '{32'h0040_0000, 32'h0040_0000, 32'h0020_0000,
		32'h0070_0000};
	logic [31:0] w_st [4] = '{32'h1, 32'h0, 32'h1, 32'h9};
	logic w_irq [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	int w_k [4] = '{2, 2, 3, 4};

	always #2.5 clk = ~clk;

	ucw_ctrl #(.SECOND_UNIT(1'b0), .ADDR_W(8)) uut (.clk(clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ev(ev), .deep_sleep(deep_sleep), .tx_req(tx_req), .tx_busy(tx_busy),
		.rts_flow(rts_flow), .tx_go(tx_go), .tx_retry(tx_retry),
		.rx_nack(rx_nack), .driver_enable_out(driver_enable_out),
		.rts_pin(rts_pin), .wake_irq(wake_irq), .irq(irq));
	// Second unit shares the bus so one write reaches both
	ucw_ctrl #(.SECOND_UNIT(1'b1), .ADDR_W(8)) uut2 (.clk(clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata2), .pready(), .pslverr(),
		.ev(ev), .deep_sleep(deep_sleep), .tx_req(tx_req), .tx_busy(tx_busy),
		.rts_flow(rts_flow), .tx_go(), .tx_retry(), .rx_nack(),
		.driver_enable_out(), .rts_pin(), .wake_irq(), .irq());
	ucw_xcvr_model #(.FRAME(10)) xcvr (.clk(clk), .nrst(nrst), .send(send),
		.pol(pol), .de(driver_enable_out), .rts(rts_pin), .tx_go(tx_go),
		.tx_req(tx_req), .tx_busy(tx_busy), .bad(bad), .frames(frames));

	// Read data is taken at the edge that ends the access phase
	always @(posedge clk) begin
		if (psel && penable && pready) begin
			cap <= prdata;
			cap2 <= prdata2;
			cap_err <= pslverr;
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) begin
			err_count++;
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk($sformatf("register %h", a), exp, cap);
	endtask

	function automatic ucw_core_ev_type mk(input int k, input logic [7:0] a);
		ucw_core_ev_type e;
		e = '0;
		e.tx_nack = (k == 0);
		e.rx_done = (k == 1 || k == 4);
		e.rx_parity_bad = (k == 1);
		e.addr_valid = (k == 2);
		e.addr_byte = a;
		e.start_bit = (k == 3);
		return e;
	endfunction

	task automatic pulse(input ucw_core_ev_type v);
		@(posedge clk);
		ev <= v;
		@(negedge clk);
		got_retry = tx_retry;
		got_nack = rx_nack;
		@(posedge clk);
		ev <= '0;
		@(negedge clk);
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end

	initial begin
		int n;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		rd(UCW_OFF_CTL3, UCW_RST_CTL3);
		rd(UCW_OFF_STS, 32'h0);
		rd(UCW_OFF_MSK, 32'h0);
		wr(UCW_OFF_CTL3, 32'h007e_ffff);
		rd(UCW_OFF_CTL3, 32'h007e_ffff);
		chk("second unit", 32'h0000_ffff, cap2);
		rd(8'h04, 32'h0);
		chk("slave error", 32'h1, cap_err);
		wr(UCW_OFF_CTL, 32'h1);
		wr(UCW_OFF_CTL3, 32'h0);
		rd(UCW_OFF_CTL3, 32'h0030_c000);
		wr(UCW_OFF_CTL, 32'h0);
		wr(UCW_OFF_CTL3, 32'h0004_0000);
		wr(UCW_OFF_MSK, 32'hd);
		wr(UCW_OFF_CTL, 32'h3);
		wr(UCW_OFF_CTL3, 32'h000a_0000);
		rd(UCW_OFF_CTL3, 32'h0004_0000);
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 3; i++) begin
				pulse(mk(k, 8'h00));
				chk("retry", i < 2, k ? got_nack : got_retry);
				if (i < 2)
					rd(UCW_OFF_STS, 32'h0);
			end
			chk("irq", k, irq);
			rd(UCW_OFF_STS, k ? 32'hc : 32'h2);
		end
		wr(UCW_OFF_CTL3, 32'h0);
		pulse(mk(0, 8'h00));
		chk("retry", 32'h0, got_retry);
		rd(UCW_OFF_STS, 32'h2);
		wr(UCW_OFF_MSK, 32'h1);
		@(posedge clk);
		deep_sleep <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(UCW_OFF_CTL, w_ctl[i]);
			wr(UCW_OFF_CTL3, w_c3[i]);
			pulse(mk(w_k[i], 8'h3a));
			chk("wake irq", w_irq[i], wake_irq);
			chk("irq", w_irq[i], irq);
			rd(UCW_OFF_STS, w_st[i]);
		end
		@(posedge clk);
		deep_sleep <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			wr(UCW_OFF_CTL, 32'h0);
			wr(UCW_OFF_CTL3, p ? 32'h0000_c000 : 32'h0000_4000);
			wr(UCW_OFF_CTL, 32'h1);
			chk("driver enable", p, driver_enable_out);
			chk("rts pin", p, rts_pin);
			@(posedge clk);
			pol <= p[0];
			send <= 1'b1;
			@(posedge clk);
			send <= 1'b0;
			n = 0;
			while (frames != p + 1 && n < 200) begin
				@(posedge clk);
				n++;
			end
			if (n >= 200)
				err_count++;
			repeat (3) @(posedge clk);
			@(negedge clk);
			chk("driver enable", p, driver_enable_out);
		end
		chk("bad cycles", 32'h0, bad);
		wr(UCW_OFF_CTL, 32'h0);
		wr(UCW_OFF_CTL3, 32'h0);
		@(posedge clk);
		rts_flow <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("rts pin", 32'h1, rts_pin);
		chk("driver enable", 32'h0, driver_enable_out);
		wrap_up();
	end
endmodule
